// ### hdl/drwm_pkg.sv
// Package: constants for the data window block mapper
package drwm_pkg;
  localparam int              DataAddrW        = 8;
  localparam int              ProgAddrW        = 12;
  localparam int              BlockNumW        = 6;
  localparam int              WindowOffsetW    = 6;
  localparam logic [7:0]      BlockSelectAddr  = 8'hc9;
  localparam logic [7:0]      WindowBaseAddr   = 8'h40;
  localparam logic [7:0]      WindowLastAddr   = 8'h7f;
  localparam int              BlockNumLsb      = 0;
  localparam int              BlockNumMsb      = 5;
  localparam logic [1:0]      ReservedBitsVal  = 2'h0;
  localparam logic [5:0]      BlockSelectReset = 6'h00;
  localparam logic [7:0]      ReadFillValue    = 8'h00;
  localparam int              ProgDepth        = 4096;

  typedef enum logic [1:0] {
    DRWM_IDLE,
    DRWM_READ,
    DRWM_DONE
  } drwm_core_state_t;

  // Program memory address from block number and offset within window
  function automatic logic [ProgAddrW-1:0] drwm_prog_addr(input logic [BlockNumW-1:0] blk,
                                                          input logic [DataAddrW-1:0] dataAddr);
    drwm_prog_addr = {blk, dataAddr[WindowOffsetW-1:0]};
  endfunction

  function automatic logic drwm_in_window(input logic [DataAddrW-1:0] dataAddr);
    drwm_in_window = (dataAddr >= WindowBaseAddr) && (dataAddr <= WindowLastAddr);
  endfunction
endpackage

// ### hdl/drwm_bus_if.sv
// Interface: core data bus between CPU side and window mapper
`timescale 1ns/1ps
interface drwm_bus_if;
  logic [7:0] addr;
  logic       writeEn;
  logic       readEn;
  logic [7:0] writeData;
  logic [7:0] readData;
  logic       readValid;
  logic       hit;

  modport mapper (
    input  addr,
    input  writeEn,
    input  readEn,
    input  writeData,
    output readData,
    output readValid,
    output hit
  );
  modport core (
    output addr,
    output writeEn,
    output readEn,
    output writeData,
    input  readData,
    input  readValid,
    input  hit
  );
endinterface

// ### hdl/drwm_mapper.sv
// Module: data window mapper, program memory seen through data space
// How it works
// - Select bits 5:0 form upper program address
// - Software writes zeros to bits 7:6
// - Write-only at C9h, reset leaves undefined
// - Software never reads or read-modify-writes it
// - Block start is block times 64
// - Window offset selects byte within block
// - Avoid changing selection inside interrupt routines
// - Update RAM image before writing register
// - Window spans data addresses 40h to 7Fh
// - 64 blocks of 64 bytes, block 0 at 0
`timescale 1ns/1ps
module drwm_mapper (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic clkEn,
  drwm_bus_if.mapper bus,
  input  wire logic        progWriteEn,
  input  wire logic [11:0] progWriteAddr,
  input  wire logic [7:0]  progWriteData,
  output logic [5:0]       curBlock
);
  logic [7:0] progMem [drwm_pkg::ProgDepth];
  logic [5:0] blockSel_q;
  logic [5:0] blockSel_d;
  logic [7:0] readData_q;
  logic [7:0] readData_d;
  logic       readValid_q;
  logic       readValid_d;
  logic [drwm_pkg::ProgAddrW-1:0] fetchAddr;
  logic       isWrite;
  logic       isRead;

  // Reset not applied: selection stays undefined until written
  assign isWrite = bus.writeEn && (bus.addr == drwm_pkg::BlockSelectAddr);
  assign isRead  = bus.readEn && drwm_pkg::drwm_in_window(bus.addr);
  assign fetchAddr = drwm_pkg::drwm_prog_addr(blockSel_q, bus.addr);

  always_comb begin
    blockSel_d = blockSel_q;
    if (isWrite) begin
      // Upper two bits dropped; software keeps them zero
      blockSel_d = bus.writeData[drwm_pkg::BlockNumMsb:drwm_pkg::BlockNumLsb];
    end
  end

  always_ff @(posedge mclk) begin
    if (clkEn) begin
      blockSel_q <= blockSel_d;
    end
  end

  always_comb begin
    readData_d  = drwm_pkg::ReadFillValue;
    readValid_d = 1'b0;
    if (isRead) begin
      readData_d  = progMem[fetchAddr];
      readValid_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      readData_q  <= drwm_pkg::ReadFillValue;
      readValid_q <= 1'b0;
    end else if (clkEn) begin
      readData_q  <= readData_d;
      readValid_q <= readValid_d;
    end
  end

  // Program store loaded by a side port; no reset on the array
  always_ff @(posedge mclk) begin
    if (clkEn && progWriteEn) begin
      progMem[progWriteAddr] <= progWriteData;
    end
  end

  // A read of C9h is not claimed, so it reads as fill value
  assign bus.hit       = isRead;
  assign bus.readData  = readData_q;
  assign bus.readValid = readValid_q;
  assign curBlock      = blockSel_q;
endmodule

// ### hdl/drwm_core.sv
// Module: CPU-side driver of the window mapper with RAM image
`timescale 1ns/1ps
module drwm_core (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       clkEn,
  drwm_bus_if.core        bus,
  input  wire logic       selReq,
  input  wire logic [5:0] selBlock,
  input  wire logic       rdReq,
  input  wire logic [5:0] rdOffset,
  output logic            busy,
  output logic [7:0]      rdData,
  output logic            rdDone,
  output logic [7:0]      imageValue
);
  drwm_pkg::drwm_core_state_t state_q;
  drwm_pkg::drwm_core_state_t state_d;
  logic [7:0] image_q;
  logic [7:0] image_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic       we_q;
  logic       we_d;
  logic       re_q;
  logic       re_d;
  logic [7:0] rd_q;
  logic [7:0] rd_d;
  logic       done_q;
  logic       done_d;

  always_comb begin
    state_d = state_q;
    image_d = image_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    we_d    = 1'b0;
    re_d    = 1'b0;
    rd_d    = rd_q;
    done_d  = 1'b0;
    case (state_q)
      drwm_pkg::DRWM_IDLE: begin
        if (selReq) begin
          // Image first so an interrupt can restore it
          image_d = {drwm_pkg::ReservedBitsVal, selBlock};
          addr_d  = drwm_pkg::BlockSelectAddr;
          wdata_d = {drwm_pkg::ReservedBitsVal, selBlock};
          we_d    = 1'b1;
        end else if (rdReq) begin
          addr_d  = drwm_pkg::WindowBaseAddr | {2'h0, rdOffset};
          re_d    = 1'b1;
          state_d = drwm_pkg::DRWM_READ;
        end
      end
      drwm_pkg::DRWM_READ: begin
        state_d = drwm_pkg::DRWM_DONE;
      end
      drwm_pkg::DRWM_DONE: begin
        if (bus.readValid) begin
          rd_d   = bus.readData;
          done_d = 1'b1;
        end
        state_d = drwm_pkg::DRWM_IDLE;
      end
      default: state_d = drwm_pkg::DRWM_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= drwm_pkg::DRWM_IDLE;
      image_q <= 8'h00;
      addr_q  <= 8'h00;
      wdata_q <= 8'h00;
      we_q    <= 1'b0;
      re_q    <= 1'b0;
      rd_q    <= 8'h00;
      done_q  <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      image_q <= image_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      we_q    <= we_d;
      re_q    <= re_d;
      rd_q    <= rd_d;
      done_q  <= done_d;
    end
  end

  assign bus.addr      = addr_q;
  assign bus.writeEn   = we_q;
  assign bus.readEn    = re_q;
  assign bus.writeData = wdata_q;
  assign busy          = (state_q != drwm_pkg::DRWM_IDLE) || we_q;
  assign rdData        = rd_q;
  assign rdDone        = done_q;
  assign imageValue    = image_q;
endmodule

// ### testbench/drwm_assertions.sv
// Checker on the bus between core and window mapper
`timescale 1ns/1ps
module drwm_assertions (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic [7:0] addr,
  input wire logic       writeEn,
  input wire logic       readEn,
  input wire logic [7:0] writeData,
  input wire logic [7:0] readData,
  input wire logic       readValid,
  input wire logic       hit
);
  logic [5:0] blk_q;
  logic       inWin;
  assign inWin = readEn && addr >= 8'h40 && addr <= 8'h7f;
  // Tracks the selection the mapper should hold
  always_ff @(posedge mclk) if (writeEn) blk_q <= writeData[5:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  AST_HIT: assert property (hit == inWin) else $error("window hit wrong");
  AST_ANSWER: assert property (inWin |=> readValid) else $error("window read unanswered");
  AST_REFUSE: assert property (!inWin |=> !readValid) else $error("answer without window read");
  AST_REG_READ: assert property (readEn |-> addr != 8'hc9 && hit) else $error("select register read");
  AST_WR: assert property (writeEn |-> addr == 8'hc9 && writeData[7:6] == 2'h0)
    else $error("bad select write");
  AST_NO_RMW: assert property (writeEn |-> !readEn) else $error("read with write");
  AST_DATA: assert property (inWin |=> readData == ({$past(blk_q), 2'h0} ^ {2'h0, $past(addr[5:0])}))
    else $error("window byte wrong");
  AST_BLOCK: assert property (writeEn ##1 inWin |=> readData[7:2] == ($past(blk_q) ^ {2'h0, $past(addr[5:2])}))
    else $error("new block not used");
endmodule

// ### testbench/testbench.sv
// Testbench: core and mapper joined through the bus interface
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        clkEn = 1'b1;
  logic        selReq = 1'b0;
  logic [5:0]  selBlock = 6'h00;
  logic        rdReq = 1'b0;
  logic [5:0]  rdOffset = 6'h00;
  logic        progWriteEn = 1'b0;
  logic [11:0] progWriteAddr = 12'h000;
  logic [7:0]  progWriteData = 8'h00;
  logic        busy, rdDone;
  logic [7:0]  rdData, imageValue;
  logic [5:0]  curBlock;
  int          error_cnt = 0;
  int          n_checks = 0;
  drwm_bus_if bus ();
  drwm_mapper i_drwm_mapper (.mclk(mclk), .reset(reset), .clkEn(clkEn), .bus(bus.mapper),
    .progWriteEn(progWriteEn), .progWriteAddr(progWriteAddr), .progWriteData(progWriteData), .curBlock(curBlock));
  drwm_core i_drwm_core (.mclk(mclk), .reset(reset), .clkEn(clkEn), .bus(bus.core), .selReq(selReq),
    .selBlock(selBlock), .rdReq(rdReq), .rdOffset(rdOffset), .busy(busy), .rdData(rdData), .rdDone(rdDone),
    .imageValue(imageValue));
  drwm_assertions i_drwm_assertions (.mclk(mclk), .reset(reset), .addr(bus.addr), .writeEn(bus.writeEn),
    .readEn(bus.readEn), .writeData(bus.writeData), .readData(bus.readData), .readValid(bus.readValid), .hit(bus.hit));
  initial forever #20 mclk = ~mclk;
  // Pattern differs per block and per offset
  function automatic logic [7:0] pat(input logic [11:0] a);
    pat = {a[11:6], 2'h0} ^ {2'h0, a[5:0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic idle();
    for (int i = 0; i < 8 && busy !== 1'b0; i++) @(negedge mclk);
  endtask
  task automatic sel(input logic [5:0] b);
    idle();
    selReq = 1'b1;
    selBlock = b;
    @(negedge mclk);
    selReq = 1'b0;
  endtask
  task automatic rd(input logic [5:0] b, input logic [5:0] off);
    idle();
    rdReq = 1'b1;
    rdOffset = off;
    @(negedge mclk);
    rdReq = 1'b0;
    for (int i = 0; i < 8 && rdDone !== 1'b1; i++) @(negedge mclk);
    chk({7'h00, rdDone}, 8'h01);
    chk(rdData, pat({b, off}));
  endtask
  task automatic load_prog();
    for (int a = 0; a < 4096; a++) begin
      progWriteEn = 1'b1;
      progWriteAddr = a[11:0];
      progWriteData = pat(a[11:0]);
      @(negedge mclk);
    end
    progWriteEn = 1'b0;
  endtask
  // Ends of memory and block edges, read once busy clears after each switch
  task automatic t_blocks();
    logic [5:0] list [5] = '{6'h00, 6'h01, 6'h25, 6'h3e, 6'h3f};
    foreach (list[k]) begin
      sel(list[k]);
      rd(list[k], 6'h00);
      rd(list[k], 6'h3f);
      chk({2'h0, curBlock}, {2'h0, list[k]});
      chk(imageValue, {2'h0, list[k]});
    end
  endtask
  task automatic t_offsets();
    sel(6'h09);
    for (int o = 0; o < 64; o++) rd(6'h09, o[5:0]);
  endtask
  // Window read in the very cycle after the select write
  task automatic t_back_to_back();
    idle();
    selReq = 1'b1;
    selBlock = 6'h2c;
    @(negedge mclk);
    selReq = 1'b0;
    rdReq = 1'b1;
    rdOffset = 6'h11;
    @(negedge mclk);
    rdReq = 1'b0;
    chk({7'h00, busy}, 8'h01);
    for (int i = 0; i < 8 && rdDone !== 1'b1; i++) @(negedge mclk);
    chk({7'h00, rdDone}, 8'h01);
    chk(rdData, pat({6'h2c, 6'h11}));
  endtask
  // Clock enable low must hold off a pending selection
  task automatic t_freeze();
    sel(6'h15);
    idle();
    clkEn = 1'b0;
    selReq = 1'b1;
    selBlock = 6'h2a;
    repeat (3) @(negedge mclk);
    chk({2'h0, curBlock}, 8'h15);
    chk(imageValue, 8'h15);
    chk({7'h00, busy}, 8'h00);
    selReq = 1'b0;
    clkEn = 1'b1;
    rd(6'h15, 6'h2a);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    load_prog();
    t_blocks();
    t_offsets();
    t_back_to_back();
    t_freeze();
    end_sim();
  end
endmodule
